// ### rtl/i2c_master_start.sv
// Purpose: i2c master sequencer with start, repeated start, stop and baud timing
// Assumes: lines are open drain, oe high pulls the line low; pins are asynchronous
// Notes:   registers on apb, zero wait state, unmapped offsets answer pslverr
`default_nettype none
module i2c_master_start #(
  parameter int QDIV = i2c_master_pkg::QDIV_DEF
) (
  input  wire logic                              ref_clk,
  input  wire logic                              rst,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [i2c_master_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]                       pwdata,
  output logic                                   pready,
  output logic                                   pslverr,
  output logic [31:0]                            prdata,
  input  wire i2c_master_pkg::lines_t            line_in,
  output i2c_master_pkg::lines_t                 line_oe
);
  i2c_master_pkg::state_t r;
  i2c_master_pkg::state_t n;
  logic                   bg_done;
  logic                   setup;
  logic                   acc;
  logic                   wr;

  localparam logic [i2c_master_pkg::QCNT_W-1:0] QCNT_LAST = i2c_master_pkg::QCNT_W'(QDIV - 1);

  assign setup = psel && !penable;
  assign acc   = psel && penable && r.pready;
  assign wr    = acc && pwrite;

  baud_gen u_bg (
    .ref_clk (ref_clk),
    .rst     (rst),
    .dec     (r.dec),
    .load    (r.bg_load),
    .reload  (r.bg_val),
    .done    (bg_done)
  );

  always_comb begin
    n         = r;
    n.s1      = line_in;
    n.s2      = r.s1;
    n.prev    = r.s2;
    n.bg_load = 1'b0;
    n.bg_val  = r.reload;
    n.dec     = 1'b0;
    // four quarter phases per instruction cycle
    if (r.qcnt == QCNT_LAST) begin
      n.qcnt  = '0;
      n.phase = r.phase + 2'd1;
      n.dec   = !r.phase[0];
    end else begin
      n.qcnt = r.qcnt + 8'h01;
    end
    // line watcher
    if (r.prev.sda && !r.s2.sda && r.s2.scl) begin
      n.start_seen = 1'b1;
      n.stop_seen  = 1'b0;
    end
    if (!r.prev.sda && r.s2.sda && r.s2.scl) begin
      n.stop_seen  = 1'b1;
      n.start_seen = 1'b0;
    end
    // apb: read data prepared in setup, write lands in access
    n.pready = setup;
    if (setup) begin
      n.pslverr = 1'b0;
      n.prdata  = '0;
      case (paddr)
        i2c_master_pkg::OFS_CTRL2:  n.prdata[6:0] = r.ctrl2;
        i2c_master_pkg::OFS_STATUS: begin
          n.prdata[i2c_master_pkg::ST_BF]    = r.bf;
          n.prdata[i2c_master_pkg::ST_START] = r.start_seen;
          n.prdata[i2c_master_pkg::ST_STOP]  = r.stop_seen;
        end
        i2c_master_pkg::OFS_RELOAD: n.prdata[6:0] = r.reload;
        i2c_master_pkg::OFS_SHIFT:  n.prdata[7:0] = r.rxbuf;
        i2c_master_pkg::OFS_FLAGS: begin
          n.prdata[i2c_master_pkg::FL_IRQ]  = r.irq;
          n.prdata[i2c_master_pkg::FL_BCL]  = r.bcl;
          n.prdata[i2c_master_pkg::FL_WRITE_COLLIDE_FLAG] = r.write_collide_flag;
        end
        i2c_master_pkg::OFS_ENABLE: n.prdata[0] = r.en;
        default:                    n.pslverr = 1'b1;
      endcase
    end
    if (acc && !pwrite && paddr == i2c_master_pkg::OFS_SHIFT && r.mode == i2c_master_pkg::M_RX) begin
      n.bf = 1'b0;
    end
    if (wr) begin
      case (paddr)
        i2c_master_pkg::OFS_CTRL2: begin
          n.ctrl2[i2c_master_pkg::C2_ACKDT] = pwdata[i2c_master_pkg::C2_ACKDT];
          // no queueing: sequence bits only take while idle and nothing pending
          if (r.fsm == i2c_master_pkg::S_IDLE && r.ctrl2[4:0] == 5'h00) begin
            n.ctrl2[4:0] = pwdata[4:0];
          end
        end
        i2c_master_pkg::OFS_RELOAD: n.reload = pwdata[6:0];
        i2c_master_pkg::OFS_SHIFT: begin
          if (r.fsm != i2c_master_pkg::S_IDLE || r.ctrl2[4:0] != 5'h00) begin
            n.write_collide_flag = 1'b1;
          end else if (r.en) begin
            n.shreg   = pwdata[7:0];
            n.bf      = 1'b1;
            n.mode    = i2c_master_pkg::M_TX;
            n.bitcnt  = '0;
            n.oe.scl  = 1'b1;
            n.bg_load = 1'b1;
            n.fsm     = i2c_master_pkg::S_BIT_LOW;
          end
        end
        i2c_master_pkg::OFS_FLAGS: begin
          n.irq  = r.irq && !pwdata[i2c_master_pkg::FL_IRQ];
          n.bcl  = r.bcl && !pwdata[i2c_master_pkg::FL_BCL];
          n.write_collide_flag = r.write_collide_flag && !pwdata[i2c_master_pkg::FL_WRITE_COLLIDE_FLAG];
        end
        i2c_master_pkg::OFS_ENABLE: n.en = pwdata[0];
        default: ;
      endcase
    end
    // sequencer; its flag sets come after the clears so a set wins
    case (r.fsm)
      i2c_master_pkg::S_IDLE: begin
        // idle keeps oe as left by the last operation
        if (r.en && r.ctrl2[i2c_master_pkg::C2_SEN]) begin
          // clock already low: someone else owns the bus, waiting would hang
          if (!r.s2.scl) begin
            n.bcl                           = 1'b1;
            n.ctrl2[i2c_master_pkg::C2_SEN] = 1'b0;
          end else if (r.s2.sda && r.s2.scl) begin
            n.bg_load = 1'b1;
            n.fsm     = i2c_master_pkg::S_ST_WAIT;
          end
        end else if (r.en && r.ctrl2[i2c_master_pkg::C2_REPEATED_START_ENABLE]) begin
          n.oe.scl = 1'b1;
          n.fsm    = i2c_master_pkg::S_RS_LOW;
        end else if (r.en && r.ctrl2[i2c_master_pkg::C2_PEN]) begin
          n.oe.sda = 1'b1;
          n.fsm    = i2c_master_pkg::S_SP_LOW;
        end else if (r.en && r.ctrl2[i2c_master_pkg::C2_RCEN]) begin
          n.mode    = i2c_master_pkg::M_RX;
          n.bitcnt  = '0;
          n.oe      = 2'b01;
          n.bg_load = 1'b1;
          n.fsm     = i2c_master_pkg::S_BIT_LOW;
        end else if (r.en && r.ctrl2[i2c_master_pkg::C2_ACKEN]) begin
          n.mode    = i2c_master_pkg::M_ACK;
          n.oe.scl  = 1'b1;
          n.oe.sda  = !r.ctrl2[i2c_master_pkg::C2_ACKDT];
          n.bg_load = 1'b1;
          n.fsm     = i2c_master_pkg::S_BIT_LOW;
        end
      end
      i2c_master_pkg::S_ST_WAIT: begin
        if (!r.s2.scl || (bg_done && !r.s2.sda)) begin
          n.bcl                           = 1'b1;
          n.ctrl2[i2c_master_pkg::C2_SEN] = 1'b0;
          n.oe                            = 2'b00;
          n.fsm                           = i2c_master_pkg::S_IDLE;
        end else if (bg_done) begin
          n.oe.sda  = 1'b1;
          n.bg_load = 1'b1;
          n.fsm     = i2c_master_pkg::S_ST_HOLD;
        end
      end
      i2c_master_pkg::S_ST_HOLD: begin
        if (bg_done) begin
          n.ctrl2[i2c_master_pkg::C2_SEN] = 1'b0;
          n.irq                           = 1'b1;
          n.fsm                           = i2c_master_pkg::S_IDLE;
        end
      end
      i2c_master_pkg::S_RS_LOW: begin
        if (!r.s2.scl) begin
          n.oe.sda  = 1'b0;
          n.bg_val  = {1'b0, r.reload[5:0]};
          n.bg_load = 1'b1;
          n.fsm     = i2c_master_pkg::S_RS_SDA;
        end
      end
      i2c_master_pkg::S_RS_SDA: begin
        if (bg_done) begin
          if (r.s2.sda) begin
            n.oe.scl = 1'b0;
            n.fsm    = i2c_master_pkg::S_RS_REL;
          end else begin
            n.bcl                            = 1'b1;
            n.ctrl2[i2c_master_pkg::C2_REPEATED_START_ENABLE] = 1'b0;
            n.oe                             = 2'b00;
            n.fsm                            = i2c_master_pkg::S_IDLE;
          end
        end
      end
      i2c_master_pkg::S_RS_REL: begin
        if (r.s2.scl && !r.s2.sda) begin
          n.bcl                            = 1'b1;
          n.ctrl2[i2c_master_pkg::C2_REPEATED_START_ENABLE] = 1'b0;
          n.oe                             = 2'b00;
          n.fsm                            = i2c_master_pkg::S_IDLE;
        end else if (r.s2.scl) begin
          n.bg_load = 1'b1;
          n.fsm     = i2c_master_pkg::S_RS_HIGH;
        end
      end
      i2c_master_pkg::S_RS_HIGH: begin
        if (!r.s2.scl) begin
          n.bcl                            = 1'b1;
          n.ctrl2[i2c_master_pkg::C2_REPEATED_START_ENABLE] = 1'b0;
          n.oe                             = 2'b00;
          n.fsm                            = i2c_master_pkg::S_IDLE;
        end else if (bg_done) begin
          n.oe.sda  = 1'b1;
          n.bg_load = 1'b1;
          n.fsm     = i2c_master_pkg::S_RS_SDA_LOW;
        end
      end
      i2c_master_pkg::S_RS_SDA_LOW: begin
        // no reload here: the counter stays suspended with data held low
        if (bg_done) begin
          n.ctrl2[i2c_master_pkg::C2_REPEATED_START_ENABLE] = 1'b0;
          n.irq                            = 1'b1;
          n.fsm                            = i2c_master_pkg::S_IDLE;
        end
      end
      i2c_master_pkg::S_BIT_LOW: begin
        // data moves only once the clock is seen low, so no false start or stop;
        // a reload so small that the rollover ends first would send stale data
        if (r.mode == i2c_master_pkg::M_TX && !r.s2.scl) begin
          n.oe.sda = (r.bitcnt != i2c_master_pkg::ACK_SLOT) && !r.shreg[7];
        end
        if (bg_done) begin
          n.oe.scl = 1'b0;
          n.fsm    = i2c_master_pkg::S_BIT_REL;
        end
      end
      i2c_master_pkg::S_BIT_REL: begin
        // a slave stretching the clock keeps us here with no reload
        if (r.s2.scl) begin
          n.bg_load = 1'b1;
          n.fsm     = i2c_master_pkg::S_BIT_HIGH;
        end
      end
      i2c_master_pkg::S_BIT_HIGH: begin
        if (bg_done) begin
          n.oe.scl = 1'b1;
          n.fsm    = i2c_master_pkg::S_BIT_LOW;
          case (r.mode)
            i2c_master_pkg::M_TX: begin
              if (r.bitcnt == i2c_master_pkg::ACK_SLOT) begin
                n.ctrl2[i2c_master_pkg::C2_ACKSTAT] = r.s2.sda;
                n.irq                               = 1'b1;
                n.oe.sda                            = 1'b0;
                n.fsm                               = i2c_master_pkg::S_IDLE;
              end else begin
                n.bitcnt  = r.bitcnt + 4'd1;
                n.shreg   = {r.shreg[6:0], 1'b0};
                n.bf      = r.bf && (r.bitcnt != i2c_master_pkg::LAST_DATA);
                n.bg_load = 1'b1;
              end
            end
            i2c_master_pkg::M_RX: begin
              n.shreg = {r.shreg[6:0], r.s2.sda};
              if (r.bitcnt == i2c_master_pkg::LAST_DATA) begin
                n.rxbuf                          = {r.shreg[6:0], r.s2.sda};
                n.bf                             = 1'b1;
                n.irq                            = 1'b1;
                n.ctrl2[i2c_master_pkg::C2_RCEN] = 1'b0;
                n.fsm                            = i2c_master_pkg::S_IDLE;
              end else begin
                n.bitcnt  = r.bitcnt + 4'd1;
                n.bg_load = 1'b1;
              end
            end
            default: begin
              n.ctrl2[i2c_master_pkg::C2_ACKEN] = 1'b0;
              n.oe.sda                          = 1'b0;
              n.irq                             = 1'b1;
              n.fsm                             = i2c_master_pkg::S_IDLE;
            end
          endcase
        end
      end
      i2c_master_pkg::S_SP_LOW: begin
        if (!r.s2.sda) begin
          n.bg_load = 1'b1;
          n.fsm     = i2c_master_pkg::S_SP_CNT1;
        end
      end
      i2c_master_pkg::S_SP_CNT1: begin
        if (bg_done) begin
          n.oe.scl = 1'b0;
          n.fsm    = i2c_master_pkg::S_SP_REL;
        end
      end
      i2c_master_pkg::S_SP_REL: begin
        if (r.s2.scl) begin
          n.bg_load = 1'b1;
          n.fsm     = i2c_master_pkg::S_SP_CNT2;
        end
      end
      i2c_master_pkg::S_SP_CNT2: begin
        if (bg_done) begin
          n.oe.sda = 1'b0;
          n.fsm    = i2c_master_pkg::S_SP_WAIT;
        end
      end
      i2c_master_pkg::S_SP_WAIT: begin
        if (r.s2.sda && r.s2.scl) begin
          n.bg_load = 1'b1;
          n.fsm     = i2c_master_pkg::S_SP_CNT3;
        end
      end
      i2c_master_pkg::S_SP_CNT3: begin
        if (bg_done) begin
          n.ctrl2[i2c_master_pkg::C2_PEN] = 1'b0;
          n.irq                           = 1'b1;
          n.fsm                           = i2c_master_pkg::S_IDLE;
        end
      end
      default: n.fsm = i2c_master_pkg::S_IDLE;
    endcase
    if (!r.en) begin
      n.fsm        = i2c_master_pkg::S_IDLE;
      n.oe         = 2'b00;
      n.ctrl2[4:0] = 5'h00;
      n.start_seen = 1'b0;
      n.stop_seen  = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign pready  = r.pready;
  assign pslverr = r.pslverr;
  assign prdata  = r.prdata;
  assign line_oe = r.oe;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_start_pull_sda: assert property (
    (r.en && r.fsm == i2c_master_pkg::S_ST_WAIT && bg_done && r.s2.sda && r.s2.scl)
    |=> (r.oe.sda && r.fsm == i2c_master_pkg::S_ST_HOLD))
    else $error("start did not pull data low");
  a_start_complete: assert property (
    (r.en && r.fsm == i2c_master_pkg::S_ST_HOLD && bg_done)
    |=> (!r.ctrl2[i2c_master_pkg::C2_SEN] && r.irq && r.oe.sda))
    else $error("start completion wrong");
  a_start_collide: assert property (
    (r.en && r.fsm == i2c_master_pkg::S_ST_WAIT && !r.s2.scl)
    |=> (r.bcl && r.fsm == i2c_master_pkg::S_IDLE && !r.oe.sda))
    else $error("start collision not flagged");
  a_start_busy: assert property (
    (r.en && r.fsm == i2c_master_pkg::S_IDLE && r.ctrl2[i2c_master_pkg::C2_SEN] && !r.s2.scl)
    |=> (r.bcl && !r.ctrl2[i2c_master_pkg::C2_SEN] && r.fsm == i2c_master_pkg::S_IDLE))
    else $error("start on low clock not flagged");
  a_write_collide_flag_start: assert property (
    (wr && paddr == i2c_master_pkg::OFS_SHIFT
     && (r.fsm == i2c_master_pkg::S_ST_WAIT || r.fsm == i2c_master_pkg::S_ST_HOLD))
    |=> (r.write_collide_flag && r.shreg == $past(r.shreg)))
    else $error("write during start not refused");
  a_ctrl_locked: assert property (
    (r.en && wr && paddr == i2c_master_pkg::OFS_CTRL2
     && r.fsm == i2c_master_pkg::S_ST_HOLD && !bg_done)
    |=> (r.ctrl2[4:1] == $past(r.ctrl2[4:1])))
    else $error("control bits changed during start");
  a_ack_stored: assert property (
    (r.en && r.fsm == i2c_master_pkg::S_BIT_HIGH && bg_done && r.mode == i2c_master_pkg::M_TX
     && r.bitcnt == i2c_master_pkg::ACK_SLOT)
    |=> (r.irq && r.ctrl2[i2c_master_pkg::C2_ACKSTAT] == $past(r.s2.sda)))
    else $error("acknowledge not stored");
  a_arb_hold: assert property (
    (r.fsm == i2c_master_pkg::S_BIT_REL && !r.s2.scl) |=> !r.bg_load)
    else $error("reload while clock held low");
  a_seen_start: assert property (
    (r.en && r.prev.sda && !r.s2.sda && r.s2.scl) |=> r.start_seen)
    else $error("start not seen");
  a_rs_finish: assert property (
    (r.en && r.fsm == i2c_master_pkg::S_RS_SDA_LOW && bg_done)
    |=> (!r.ctrl2[i2c_master_pkg::C2_REPEATED_START_ENABLE] && r.oe.sda && !r.bg_load) ##1 !r.bg_load)
    else $error("repeated start end wrong");
  a_stop_done: assert property (
    (r.en && r.fsm == i2c_master_pkg::S_SP_CNT3 && bg_done)
    |=> (!r.ctrl2[i2c_master_pkg::C2_PEN] && r.irq))
    else $error("stop completion wrong");
  a_disable_clear: assert property (
    !r.en |=> (!r.start_seen && !r.stop_seen))
    else $error("seen flags not cleared");
  a_tx_kick: assert property (
    (r.en && wr && paddr == i2c_master_pkg::OFS_SHIFT && r.fsm == i2c_master_pkg::S_IDLE
     && r.ctrl2[4:0] == 5'h00) |=> (r.bg_load && r.oe.scl) ##[1:2] !r.bg_load)
    else $error("shift write did not start counter");

  c_start: cover property (r.fsm == i2c_master_pkg::S_ST_HOLD && bg_done);
  c_rstart: cover property (r.fsm == i2c_master_pkg::S_RS_SDA_LOW && bg_done);
  c_byte: cover property (r.fsm == i2c_master_pkg::S_BIT_HIGH && bg_done
                          && r.bitcnt == i2c_master_pkg::ACK_SLOT);
  c_stop: cover property (r.fsm == i2c_master_pkg::S_SP_CNT3 && bg_done);
endmodule : i2c_master_start
`default_nettype wire

// ### rtl/i2c_master_pkg.sv
// Purpose: shared constants and types of the i2c master start and baud block
// Assumes: apb register map with 32-bit aligned words
// Notes:   every offset and field position lives here; reset loads all zero in the modules
`default_nettype none
package i2c_master_pkg;
  localparam int          APB_AW      = 8;
  localparam logic [7:0]  OFS_CTRL2   = 8'h00;
  localparam logic [7:0]  OFS_STATUS  = 8'h04;
  localparam logic [7:0]  OFS_RELOAD  = 8'h08;
  localparam logic [7:0]  OFS_SHIFT   = 8'h0C;
  localparam logic [7:0]  OFS_FLAGS   = 8'h10;
  localparam logic [7:0]  OFS_ENABLE  = 8'h14;
  // serial_ctrl_two fields
  localparam int          C2_SEN      = 0;
  localparam int          C2_REPEATED_START_ENABLE     = 1;
  localparam int          C2_PEN      = 2;
  localparam int          C2_RCEN     = 3;
  localparam int          C2_ACKEN    = 4;
  localparam int          C2_ACKDT    = 5;
  localparam int          C2_ACKSTAT  = 6;
  localparam int          C2_LOCK_W   = 5;
  // port_status_reg fields
  localparam int          ST_BF       = 0;
  localparam int          ST_START    = 3;
  localparam int          ST_STOP     = 4;
  // flag register fields, write one to clear
  localparam int          FL_IRQ      = 0;
  localparam int          FL_BCL      = 1;
  localparam int          FL_WRITE_COLLIDE_FLAG     = 2;
  localparam int          RELOAD_W    = 7;
  localparam int          QCNT_W      = 8;
  localparam int          QDIV_DEF    = 4;
  localparam logic [3:0]  LAST_DATA   = 4'd7;
  localparam logic [3:0]  ACK_SLOT    = 4'd8;

  typedef enum logic [4:0] {
    S_IDLE, S_ST_WAIT, S_ST_HOLD, S_RS_LOW, S_RS_SDA, S_RS_REL, S_RS_HIGH,
    S_RS_SDA_LOW, S_BIT_LOW, S_BIT_REL, S_BIT_HIGH, S_SP_LOW, S_SP_CNT1,
    S_SP_REL, S_SP_CNT2, S_SP_WAIT, S_SP_CNT3
  } fsm_t;

  typedef enum logic [1:0] {M_TX, M_RX, M_ACK} bitmode_t;

  typedef struct packed {
    logic sda;
    logic scl;
  } lines_t;

  typedef struct packed {
    logic                run;
    logic [RELOAD_W-1:0] count;
    logic                done;
  } bg_state_t;

  typedef struct packed {
    fsm_t                fsm;
    bitmode_t            mode;
    lines_t              s1;
    lines_t              s2;
    lines_t              prev;
    lines_t              oe;
    logic [6:0]          ctrl2;
    logic [RELOAD_W-1:0] reload;
    logic [RELOAD_W-1:0] bg_val;
    logic                bg_load;
    logic [7:0]          shreg;
    logic [7:0]          rxbuf;
    logic                bf;
    logic                start_seen;
    logic                stop_seen;
    logic                irq;
    logic                bcl;
    logic                write_collide_flag;
    logic                en;
    logic [3:0]          bitcnt;
    logic [QCNT_W-1:0]   qcnt;
    logic [1:0]          phase;
    logic                dec;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
  } state_t;
endpackage : i2c_master_pkg
`default_nettype wire

// ### rtl/baud_gen.sv
// Purpose: 7-bit down counter that times one rollover_period
// Assumes: dec is a one-cycle enable at quarter_phase_two and quarter_phase_four
// Notes:   stops at zero until the next load, done is a one-cycle pulse
`default_nettype none
module baud_gen (
  input  wire logic                                ref_clk,
  input  wire logic                                rst,
  input  wire logic                                dec,
  input  wire logic                                load,
  input  wire logic [i2c_master_pkg::RELOAD_W-1:0] reload,
  output logic                                     done
);
  i2c_master_pkg::bg_state_t r;
  i2c_master_pkg::bg_state_t n;

  always_comb begin
    n      = r;
    n.done = 1'b0;
    if (load) begin
      n.count = reload;
      n.run   = 1'b1;
    end else if (r.run && dec) begin
      if (r.count == '0) begin
        // one rollover is reload+1 decrements
        n.run  = 1'b0;
        n.done = 1'b1;
      end else begin
        n.count = r.count - 7'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign done = r.done;
endmodule : baud_gen
`default_nettype wire

// ### tb/i2c_slave_model.sv
// Purpose: behavioural i2c slave on the far side of the master
// Assumes: open-drain wires with pull-ups, oe high pulls low
// Notes:   acks only the first byte after each start; records that first byte;
//          after a read address it sends one fixed byte
`default_nettype none
module i2c_slave_model (
  input  wire logic  scl,
  input  wire logic  sda,
  output logic       sda_oe,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  // byte sent after a read address, value arbitrary
  localparam logic [7:0] RD_PAT = 8'h3C;
  int cnt = 0;
  initial sda_oe = 1'b0;
  initial rx_byte = 8'h00;
  // a start, plain or repeated, restarts the byte framing
  always @(negedge sda) if (scl === 1'b1) cnt = 0;
  always @(posedge scl) begin
    if (cnt < 8) rx_byte = {rx_byte[6:0], sda};
    cnt++;
  end
  // pull data low inside the ninth bit and, after a read address, for each zero bit of RD_PAT; released at its falling clock
  always @(negedge scl)
    sda_oe = (cnt == 8)
             || (rx_byte[0] && cnt >= 9 && cnt <= 16 && !RD_PAT[16 - cnt]);
endmodule : i2c_slave_model
`default_nettype wire

// ### tb/test_i2c_master_start.sv
// Purpose: directed apb tests of start, byte, repeated start, stop and collision
// Assumes: QDIV 1 and reload 2 keep each rollover short
// Notes:   the bench may hold scl low to force a bus collision
`default_nettype none
module test_i2c_master_start;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd_v;
  logic        err_v;
  logic        scl_hold = 1'b0;
  int          errors = 0;
  int          checks = 0;
  int          cyc = 0;
  wire logic        pready;
  wire logic        pslverr;
  wire logic [31:0] prdata;
  wire logic        slv_oe;
  wire logic [7:0]  slv_byte;
  i2c_master_pkg::lines_t line_in;
  i2c_master_pkg::lines_t line_oe;
  // one assignment so both wires change in the same update
  assign line_in = {~(line_oe.sda | slv_oe), ~(line_oe.scl | scl_hold)};
  always #2 ref_clk = ~ref_clk;
  i2c_master_start #(.QDIV(1)) u_i2c_master_start (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .line_in(line_in), .line_oe(line_oe));
  i2c_slave_model u_i2c_slave_model (.scl(line_in.scl), .sda(line_in.sda), .sda_oe(slv_oe),
    .rx_byte(slv_byte));
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // poll a register bit until it shows v; the cycle ceiling cuts a hang
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    do apb(1'b0, a, 32'h0); while (rd_v[b] !== v);
  endtask : poll
  task automatic finish_test();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, i2c_master_pkg::OFS_CTRL2, 32'h0); chk(rd_v, 32'h0);
    apb(1'b0, 8'h40, 32'h0); chk({31'h0, err_v}, 32'h1);
    apb(1'b1, i2c_master_pkg::OFS_RELOAD, 32'h2);
    apb(1'b1, i2c_master_pkg::OFS_ENABLE, 32'h1);
    apb(1'b1, i2c_master_pkg::OFS_CTRL2, 32'h1);
    apb(1'b1, i2c_master_pkg::OFS_SHIFT, 32'h55);
    apb(1'b1, i2c_master_pkg::OFS_CTRL2, 32'h4);
    poll(i2c_master_pkg::OFS_CTRL2, i2c_master_pkg::C2_SEN, 1'b0);
    chk(rd_v, 32'h0);
    chk({30'h0, line_in}, 32'h1);
    apb(1'b0, i2c_master_pkg::OFS_FLAGS, 32'h0); chk(rd_v, 32'h5);
    apb(1'b0, i2c_master_pkg::OFS_STATUS, 32'h0); chk(rd_v, 32'h8);
    apb(1'b1, i2c_master_pkg::OFS_FLAGS, 32'h7);
    apb(1'b1, i2c_master_pkg::OFS_SHIFT, 32'hA4);
    poll(i2c_master_pkg::OFS_FLAGS, i2c_master_pkg::FL_IRQ, 1'b1);
    chk({24'h0, slv_byte}, 32'hA4);
    apb(1'b0, i2c_master_pkg::OFS_CTRL2, 32'h0); chk(rd_v, 32'h0);
    chk({31'h0, line_in.scl}, 32'h0);
    apb(1'b1, i2c_master_pkg::OFS_FLAGS, 32'h7);
    apb(1'b1, i2c_master_pkg::OFS_CTRL2, 32'h2);
    apb(1'b1, i2c_master_pkg::OFS_SHIFT, 32'h11);
    poll(i2c_master_pkg::OFS_CTRL2, i2c_master_pkg::C2_REPEATED_START_ENABLE, 1'b0);
    chk({30'h0, line_in}, 32'h1);
    apb(1'b0, i2c_master_pkg::OFS_FLAGS, 32'h0); chk(rd_v, 32'h5);
    apb(1'b1, i2c_master_pkg::OFS_FLAGS, 32'h7);
    apb(1'b1, i2c_master_pkg::OFS_SHIFT, 32'hA5);
    poll(i2c_master_pkg::OFS_FLAGS, i2c_master_pkg::FL_IRQ, 1'b1);
    chk({24'h0, slv_byte}, 32'hA5);
    apb(1'b1, i2c_master_pkg::OFS_FLAGS, 32'h7);
    apb(1'b1, i2c_master_pkg::OFS_CTRL2, 32'h8);
    poll(i2c_master_pkg::OFS_FLAGS, i2c_master_pkg::FL_IRQ, 1'b1);
    apb(1'b0, i2c_master_pkg::OFS_STATUS, 32'h0); chk(rd_v, 32'h9);
    apb(1'b0, i2c_master_pkg::OFS_SHIFT, 32'h0); chk(rd_v, 32'h3C);
    apb(1'b1, i2c_master_pkg::OFS_FLAGS, 32'h7);
    apb(1'b1, i2c_master_pkg::OFS_CTRL2, 32'h10);
    poll(i2c_master_pkg::OFS_FLAGS, i2c_master_pkg::FL_IRQ, 1'b1);
    apb(1'b0, i2c_master_pkg::OFS_CTRL2, 32'h0); chk(rd_v, 32'h0);
    apb(1'b1, i2c_master_pkg::OFS_FLAGS, 32'h7);
    apb(1'b1, i2c_master_pkg::OFS_CTRL2, 32'h4);
    poll(i2c_master_pkg::OFS_FLAGS, i2c_master_pkg::FL_IRQ, 1'b1);
    apb(1'b0, i2c_master_pkg::OFS_CTRL2, 32'h0); chk(rd_v, 32'h0);
    apb(1'b0, i2c_master_pkg::OFS_STATUS, 32'h0); chk(rd_v, 32'h10);
    chk({30'h0, line_in}, 32'h3);
    apb(1'b1, i2c_master_pkg::OFS_FLAGS, 32'h7);
    scl_hold <= 1'b1;
    apb(1'b1, i2c_master_pkg::OFS_CTRL2, 32'h1);
    poll(i2c_master_pkg::OFS_FLAGS, i2c_master_pkg::FL_BCL, 1'b1);
    apb(1'b0, i2c_master_pkg::OFS_CTRL2, 32'h0); chk(rd_v, 32'h0);
    scl_hold <= 1'b0;
    apb(1'b1, i2c_master_pkg::OFS_ENABLE, 32'h0);
    apb(1'b0, i2c_master_pkg::OFS_STATUS, 32'h0); chk(rd_v, 32'h0);
    finish_test();
  end
endmodule : test_i2c_master_start
`default_nettype wire
